// *** src/nci_cmd_if.sv ***
// NVM command front end: command object, launch, lock, checks and status
`timescale 1ns/100ps
`include "nci_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module nci_cmd_if #(
  parameter int OBJ_WORDS = `NCI_OBJ_WORDS
) (
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic [2:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic              special_mode_i,
  input  wire nci_pkg::nci_rsp_t op_rsp_i,
  output nci_pkg::nci_op_t       op_req_o,
  output logic                   pa_read_ok_o,
  output logic                   da_margin_read_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    nci_pkg::nci_state_t                         st;
    logic [2:0]                                  idx;
    logic [OBJ_WORDS-1:0][15:0]                  obj;
    logic                                        command_complete_flag;
    logic                                        access_error_flag;
    logic                                        protection_violation_flag;
    logic                                        mg1;
    logic                                        mg0;
    logic [2:0]                                  pa_prot;
    logic                                        da_open;
    logic [1:0]                                  margin;
    logic [7:0]                                  rdata;
    nci_pkg::nci_op_t                            op;
    logic                                        pa_read_ok;
    logic                                        da_margin;
  } nci_regs_t;

  nci_regs_t state_r;
  nci_regs_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (OBJ_WORDS <= `NCI_IDX_COUNT) begin : g_words_low
    $error("object array too small for the count word");
  end

  if (OBJ_WORDS > `NCI_OBJ_WORDS) begin : g_words_high
    $error("object array larger than the implemented words");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic cmd_known(input logic [7:0] c);
    case (c)
      `NCI_CMD_EVB,
      `NCI_CMD_EV_PSEC,
      `NCI_CMD_ERA_ALL,
      `NCI_CMD_ERA_BLK,
      `NCI_CMD_UNSECURE,
      `NCI_CMD_USR_MRG,
      `NCI_CMD_FLD_MRG,
      `NCI_CMD_EV_DSEC,
      `NCI_CMD_PROG_D,
      `NCI_CMD_ERA_SEC: cmd_known = 1'b1;
      default:          cmd_known = 1'b0;
    endcase
  endfunction : cmd_known

  function automatic logic in_data_array(input logic [17:0] a);
    in_data_array = (a >= `NCI_DA_BASE) && (a < `NCI_DA_END);
  endfunction : in_data_array

  // Commands that must target the data array window
  function automatic logic data_cmd(input logic [7:0] c);
    case (c)
      `NCI_CMD_EV_DSEC,
      `NCI_CMD_PROG_D,
      `NCI_CMD_ERA_SEC: data_cmd = 1'b1;
      default:          data_cmd = 1'b0;
    endcase
  endfunction : data_cmd

  // Margin setting commands
  function automatic logic margin_cmd(input logic [7:0] c);
    margin_cmd = (c == `NCI_CMD_USR_MRG) || (c == `NCI_CMD_FLD_MRG);
  endfunction : margin_cmd

  // Commands that erase both arrays
  function automatic logic mass_cmd(input logic [7:0] c);
    mass_cmd = (c == `NCI_CMD_ERA_ALL) || (c == `NCI_CMD_UNSECURE);
  endfunction : mass_cmd

  // Program array reads may run beside data margin read, program, sector erase
  function automatic logic pa_read_allowed(input logic [7:0] c, input logic [1:0] m);
    case (c)
      `NCI_CMD_PROG_D,
      `NCI_CMD_ERA_SEC: pa_read_allowed = 1'b1;
      `NCI_CMD_EVB,
      `NCI_CMD_EV_DSEC: pa_read_allowed = (m != `NCI_MARGIN_NORMAL);
      default:          pa_read_allowed = 1'b0;
    endcase
  endfunction : pa_read_allowed

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [7:0]  cur_cmd;
  logic [17:0] cur_addr;
  logic        wr_idx_ok;
  logic        launch;
  logic        acc_bad;
  logic        prot_bad;
  logic        all_open;
  logic [1:0]  cur_sel;
  logic        da_target;

  always_comb begin
    state_nxt = state_r;
    cur_cmd   = state_r.obj[`NCI_IDX_CMD][15:8];
    cur_addr  = {state_r.obj[`NCI_IDX_CMD][1:0], state_r.obj[`NCI_IDX_ADDR]};
    cur_sel   = state_r.obj[`NCI_IDX_CMD][1:0];
    da_target = (cur_cmd == `NCI_CMD_EVB)
              ? (cur_sel == `NCI_SEL_DATA)
              : in_data_array(cur_addr);
    wr_idx_ok = (state_r.idx < 3'(OBJ_WORDS));
    launch    = 1'b0;
    acc_bad   = 1'b0;
    prot_bad  = 1'b0;
    all_open  = state_r.pa_prot[`NCI_PA_LOW_OFF] & state_r.pa_prot[`NCI_PA_HIGH_OFF]
              & state_r.pa_prot[`NCI_PA_OPEN] & state_r.da_open;
    state_nxt.rdata = `NCI_RD_ZERO;

    // Register reads, data one cycle later
    if (reg_rd_i) begin
      case (reg_addr_i)
        `NCI_OFS_INDEX:   state_nxt.rdata = {5'h00, state_r.idx};
        `NCI_OFS_STATUS: begin
          state_nxt.rdata[`NCI_ST_COMMAND_COMPLETE_FLAG]   = state_r.command_complete_flag;
          state_nxt.rdata[`NCI_ST_ACCESS_ERROR_FLAG] = state_r.access_error_flag;
          state_nxt.rdata[`NCI_ST_PROTECTION_VIOLATION_FLAG] = state_r.protection_violation_flag;
          state_nxt.rdata[`NCI_ST_MG1]    = state_r.mg1;
          state_nxt.rdata[`NCI_ST_MG0]    = state_r.mg0;
        end
        `NCI_OFS_PA_PROT: state_nxt.rdata = {5'h00, state_r.pa_prot};
        `NCI_OFS_DA_PROT: state_nxt.rdata[`NCI_DA_OPEN] = state_r.da_open;
        `NCI_OFS_OBJ_HI: begin
          if (wr_idx_ok) begin
            state_nxt.rdata = state_r.obj[state_r.idx][15:8];
          end else begin
            state_nxt.rdata = `NCI_RD_ZERO;
          end
        end
        `NCI_OFS_OBJ_LO: begin
          if (wr_idx_ok) begin
            state_nxt.rdata = state_r.obj[state_r.idx][7:0];
          end else begin
            state_nxt.rdata = `NCI_RD_ZERO;
          end
        end
        default:          state_nxt.rdata = `NCI_RD_ZERO;
      endcase
    end

    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `NCI_OFS_INDEX:   state_nxt.idx = reg_wdata_i[2:0];
        `NCI_OFS_STATUS: begin
          if (reg_wdata_i[`NCI_ST_ACCESS_ERROR_FLAG]) begin
            state_nxt.access_error_flag = 1'b0;
          end
          if (reg_wdata_i[`NCI_ST_PROTECTION_VIOLATION_FLAG]) begin
            state_nxt.protection_violation_flag = 1'b0;
          end
          if (reg_wdata_i[`NCI_ST_COMMAND_COMPLETE_FLAG] && state_r.command_complete_flag && !state_r.access_error_flag && !state_r.protection_violation_flag) begin
            launch = 1'b1;
          end
        end
        `NCI_OFS_PA_PROT: begin
          if (state_r.command_complete_flag) begin
            state_nxt.pa_prot = reg_wdata_i[2:0];
          end
        end
        `NCI_OFS_DA_PROT: begin
          if (state_r.command_complete_flag) begin
            state_nxt.da_open = reg_wdata_i[`NCI_DA_OPEN];
          end
        end
        `NCI_OFS_OBJ_HI: begin
          if (state_r.command_complete_flag && wr_idx_ok) begin
            state_nxt.obj[state_r.idx][15:8] = reg_wdata_i;
          end
        end
        `NCI_OFS_OBJ_LO: begin
          if (state_r.command_complete_flag && wr_idx_ok) begin
            state_nxt.obj[state_r.idx][7:0] = reg_wdata_i;
          end
        end
        default: ;
      endcase
    end

    // Command sequencing
    case (state_r.st)
      nci_pkg::NCI_IDLE: begin
        state_nxt.command_complete_flag = 1'b1;
        if (launch) begin
          state_nxt.command_complete_flag = 1'b0;
          state_nxt.mg1  = 1'b0;
          state_nxt.mg0  = 1'b0;
          state_nxt.st   = nci_pkg::NCI_CHECK;
        end
      end

      nci_pkg::NCI_CHECK: begin
        if (!cmd_known(cur_cmd)) begin
          acc_bad = 1'b1;
        end
        if (cur_cmd == `NCI_CMD_EVB && state_r.idx != `NCI_IDX_CMD) begin
          acc_bad = 1'b1;
        end
        if (cur_cmd == `NCI_CMD_FLD_MRG && !special_mode_i) begin
          acc_bad = 1'b1;
        end
        if (data_cmd(cur_cmd) && !in_data_array(cur_addr)) begin
          acc_bad = 1'b1;
        end
        if (cur_cmd == `NCI_CMD_ERA_ALL && !all_open) begin
          prot_bad = 1'b1;
        end
        if (cur_cmd == `NCI_CMD_ERA_BLK && in_data_array(cur_addr) && !state_r.da_open) begin
          prot_bad = 1'b1;
        end
        state_nxt.op.cmd        = cur_cmd;
        state_nxt.op.addr       = cur_addr;
        state_nxt.op.count      = state_r.obj[`NCI_IDX_COUNT];
        state_nxt.op.block_sel  = cur_sel;
        state_nxt.op.margin     = state_r.margin;
        state_nxt.op.data_array = da_target;
        if (acc_bad) begin
          state_nxt.access_error_flag = 1'b1;
          state_nxt.command_complete_flag   = 1'b1;
          state_nxt.st     = nci_pkg::NCI_IDLE;
        end else if (prot_bad) begin
          state_nxt.protection_violation_flag = 1'b1;
          state_nxt.command_complete_flag   = 1'b1;
          state_nxt.st     = nci_pkg::NCI_IDLE;
        end else begin
          state_nxt.op.valid = 1'b1;
          state_nxt.st       = nci_pkg::NCI_EXEC;
        end
      end

      nci_pkg::NCI_EXEC: begin
        if (op_rsp_i.done) begin
          state_nxt.op.valid = 1'b0;
          state_nxt.command_complete_flag     = 1'b1;
          state_nxt.st       = nci_pkg::NCI_IDLE;
          if (op_rsp_i.result_we && op_rsp_i.result_idx < 3'(OBJ_WORDS)) begin
            state_nxt.obj[op_rsp_i.result_idx] = op_rsp_i.result;
          end
          if (margin_cmd(state_r.op.cmd)) begin
            state_nxt.margin = state_r.obj[`NCI_IDX_ADDR][1:0];
          end
          if (mass_cmd(state_r.op.cmd)) begin
            state_nxt.margin = `NCI_MARGIN_NORMAL;
          end
          state_nxt.mg1 = op_rsp_i.read_err | op_rsp_i.uncorr_err | op_rsp_i.blank_fail;
          state_nxt.mg0 = op_rsp_i.uncorr_err | op_rsp_i.blank_fail;
        end
      end

      default: begin
        state_nxt.st   = nci_pkg::NCI_IDLE;
        state_nxt.command_complete_flag = 1'b1;
      end
    endcase

    // Simultaneous operation grant
    state_nxt.pa_read_ok = (state_nxt.st == nci_pkg::NCI_IDLE)
                         || (state_nxt.op.valid && state_nxt.op.data_array
                             && pa_read_allowed(state_nxt.op.cmd, state_nxt.op.margin));
    state_nxt.da_margin  = (state_nxt.margin != `NCI_MARGIN_NORMAL);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r            <= '0;
      state_r.st         <= nci_pkg::NCI_IDLE;
      state_r.idx        <= `NCI_RST_INDEX;
      state_r.command_complete_flag       <= 1'b1;
      state_r.pa_prot    <= `NCI_RST_PROT;
      state_r.margin     <= `NCI_RST_MARGIN;
      state_r.pa_read_ok <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_o      = state_r.rdata;
  assign op_req_o         = state_r.op;
  assign pa_read_ok_o     = state_r.pa_read_ok;
  assign da_margin_read_o = state_r.da_margin;

endmodule : nci_cmd_if

// *** shared/nci_consts.svh ***
// Offsets, field positions, command codes and reset values for the NVM command interface
`ifndef NCI_CONSTS_SVH
`define NCI_CONSTS_SVH

// Register offsets on the byte-wide register port
`define NCI_OFS_INDEX     3'h0
`define NCI_OFS_STATUS    3'h1
`define NCI_OFS_PA_PROT   3'h2
`define NCI_OFS_DA_PROT   3'h3
`define NCI_OFS_OBJ_HI    3'h4
`define NCI_OFS_OBJ_LO    3'h5

// Status register fields
`define NCI_ST_COMMAND_COMPLETE_FLAG       7
`define NCI_ST_ACCESS_ERROR_FLAG     5
`define NCI_ST_PROTECTION_VIOLATION_FLAG     4
`define NCI_ST_MG1        1
`define NCI_ST_MG0        0

// Protect register fields
`define NCI_PA_LOW_OFF    0
`define NCI_PA_HIGH_OFF   1
`define NCI_PA_OPEN       2
`define NCI_DA_OPEN       7

// Command object words
`define NCI_OBJ_WORDS     6
`define NCI_IDX_CMD       3'h0
`define NCI_IDX_ADDR      3'h1
`define NCI_IDX_COUNT     3'h2

// Command codes
`define NCI_CMD_EVB       8'h02
`define NCI_CMD_ERA_ALL   8'h08
`define NCI_CMD_ERA_BLK   8'h09
`define NCI_CMD_UNSECURE  8'h0B
`define NCI_CMD_USR_MRG   8'h0D
`define NCI_CMD_FLD_MRG   8'h0E
`define NCI_CMD_EV_DSEC   8'h10
`define NCI_CMD_PROG_D    8'h11
`define NCI_CMD_ERA_SEC   8'h12
`define NCI_CMD_EV_PSEC   8'h03

// Block selection code for the data array
`define NCI_SEL_DATA      2'h0

// Data array address window (global address)
`define NCI_DA_BASE       18'h04000
`define NCI_DA_END        18'h04800

// Reset values
`define NCI_RST_INDEX     3'h0
`define NCI_RST_PROT      3'h0
`define NCI_RST_MARGIN    2'h0
`define NCI_MARGIN_NORMAL 2'h0
`define NCI_RD_ZERO       8'h00
`define NCI_WORD_ZERO     16'h0000

`endif

// *** shared/nci_pkg.sv ***
// Types for the NVM command interface
package nci_pkg;

  typedef enum logic [1:0] {
    NCI_IDLE,
    NCI_CHECK,
    NCI_EXEC
  } nci_state_t;

  // Request toward the array engine
  typedef struct packed {
    logic        valid;
    logic [7:0]  cmd;
    logic [17:0] addr;
    logic [15:0] count;
    logic [1:0]  block_sel;
    logic        data_array;
    logic [1:0]  margin;
  } nci_op_t;

  // Answer from the array engine
  typedef struct packed {
    logic        done;
    logic        read_err;
    logic        uncorr_err;
    logic        blank_fail;
    logic        result_we;
    logic [2:0]  result_idx;
    logic [15:0] result;
  } nci_rsp_t;

  typedef logic [15:0] nci_word_t;

endpackage : nci_pkg

// *** sim/nci_cmd_if_monitor.sv ***
// Port checker for the NVM command front end
`timescale 1ns/100ps
module nci_cmd_if_monitor (
  input wire logic              mclk_i,
  input wire logic              reset_i,
  input wire logic [2:0]        reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic              special_mode_i,
  input wire nci_pkg::nci_rsp_t op_rsp_i,
  input wire nci_pkg::nci_op_t  op_req_o,
  input wire logic              pa_read_ok_o,
  input wire logic              da_margin_read_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  sequence launch_wr;
    reg_wr_i && reg_addr_i == 3'h1 && reg_wdata_i[7] && !op_req_o.valid;
  endsequence
  sequence run_start;
    $rose(op_req_o.valid);
  endsequence
  sequence run_busy;
    op_req_o.valid && !op_rsp_i.done;
  endsequence

  a_launch_origin: assert property (run_start |-> $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == 3'h1)
    else $error("run started without launch write");
  a_launch_gap: assert property (launch_wr |=> !op_req_o.valid)
    else $error("run started one cycle early");
  a_valid_hold: assert property (run_busy |=> op_req_o.valid)
    else $error("run ended without done");
  a_valid_end: assert property (op_req_o.valid && op_rsp_i.done |=> !op_req_o.valid)
    else $error("run did not end after done");
  a_fields_stable: assert property (run_busy |=> $stable(op_req_o.cmd) && $stable(op_req_o.addr))
    else $error("request fields moved during run");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_rd_unmapped: assert property (reg_rd_i && reg_addr_i[2:1] == 2'h3 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_data_target: assert property (op_req_o.valid && op_req_o.cmd inside {8'h10, 8'h11, 8'h12}
    |-> op_req_o.data_array)
    else $error("data command not aimed at data array");
  a_field_special: assert property ($rose(op_req_o.valid) && op_req_o.cmd == 8'h0E |-> $past(special_mode_i))
    else $error("field margin run outside special mode");
  a_mass_block: assert property (op_req_o.valid && $past(op_req_o.valid)
    && op_req_o.cmd inside {8'h08, 8'h0B} |-> !pa_read_ok_o)
    else $error("program reads allowed during mass erase");
  a_write_read_ok: assert property (op_req_o.valid && $past(op_req_o.valid)
    && op_req_o.cmd inside {8'h11, 8'h12} |-> pa_read_ok_o)
    else $error("program reads blocked during data write");
endmodule : nci_cmd_if_monitor

bind nci_cmd_if nci_cmd_if_monitor mon_u (.mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .special_mode_i(special_mode_i), .op_rsp_i(op_rsp_i), .op_req_o(op_req_o),
  .pa_read_ok_o(pa_read_ok_o), .da_margin_read_o(da_margin_read_o));

// *** sim/nci_cmd_if_tb_top.sv ***
// Self-checking bench for the NVM command front end
`timescale 1ns/100ps
module nci_cmd_if_tb_top;
  logic              mclk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic [2:0]        reg_addr_i = 3'h0;
  logic [7:0]        reg_wdata_i = 8'h00;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [7:0]        reg_rdata_o;
  logic              special_mode_i = 1'b0;
  nci_pkg::nci_rsp_t op_rsp_i = '0;
  nci_pkg::nci_op_t  op_req_o;
  logic              pa_read_ok_o;
  logic              da_margin_read_o;
  int                err_count = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  int                seed = 32'h167DA24A;
  int                margin = 0;
  int                obj [0:7] = '{default: 0};
  logic [7:0]        rd_v;

  always #4 mclk_i = ~mclk_i;

  nci_cmd_if dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .special_mode_i(special_mode_i),
    .op_rsp_i(op_rsp_i), .op_req_o(op_req_o), .pa_read_ok_o(pa_read_ok_o), .da_margin_read_o(da_margin_read_o));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    #1 rd_v = reg_rdata_o;
  endtask : rd

  task automatic put(input logic [2:0] i, input logic [15:0] w);
    wr(3'h0, {5'h00, i});
    wr(3'h4, w[15:8]);
    wr(3'h5, w[7:0]);
    if (i < 3'h6) obj[i] = w;
  endtask : put

  task automatic chk_word(input logic [2:0] i);
    logic [7:0] hi;
    wr(3'h0, {5'h00, i});
    rd(3'h4);
    hi = rd_v;
    rd(3'h5);
    check("object_word", {hi, rd_v}, obj[i]);
  endtask : chk_word

  task automatic stat(input logic [7:0] e);
    rd(3'h1);
    check("status", rd_v, e);
  endtask : stat

  task automatic run_cmd(input logic [7:0] code, input logic [1:0] sel, input logic [15:0] w1,
                         input logic [2:0] idx, input logic [7:0] err);
    logic [2:0]  f;
    logic [15:0] r;
    f = 3'($random(seed));
    r = 16'($random(seed));
    put(3'h0, {code, 6'h00, sel});
    put(3'h1, w1);
    put(3'h2, 16'h0003);
    wr(3'h0, {5'h00, idx});
    wr(3'h1, 8'h80);
    for (int n = 0; n < 8 && op_req_o.valid !== 1'b1; n++) begin
      @(posedge mclk_i);
      #1;
    end
    if (err != 8'h00) begin
      check("run_valid", op_req_o.valid, 1'b0);
      stat(8'h80 | err);
      wr(3'h1, 8'h30);
      stat(8'h80);
    end else begin
      check("run_cmd", op_req_o.cmd, code);
      check("run_addr", op_req_o.addr, {sel, w1});
      check("run_count", op_req_o.count, 16'h0003);
      check("run_sel", op_req_o.block_sel, sel);
      check("run_margin", op_req_o.margin, margin);
      check("run_da", op_req_o.data_array,
            (code == 8'h02) ? (sel == 2'h0) : ({sel, w1} inside {[18'h04000:18'h047FF]}));
      if (code == 8'h10 || (code == 8'h02 && sel == 2'h0)) check("pa_ok", pa_read_ok_o, margin != 0);
      stat(8'h00);
      wr(3'h0, 8'h01);
      wr(3'h4, ~w1[15:8]);
      if (code == 8'h11 || code == 8'h12) check("pa_ok", pa_read_ok_o, 1'b1);
      if (code == 8'h08 || code == 8'h0B) check("pa_ok", pa_read_ok_o, 1'b0);
      @(posedge mclk_i);
      op_rsp_i <= '{done: 1'b1, read_err: f[0], uncorr_err: f[1], blank_fail: f[2], result_we: 1'b1,
                    result_idx: 3'h3, result: r};
      @(posedge mclk_i);
      op_rsp_i <= '0;
      obj[3] = r;
      if (code == 8'h0D || code == 8'h0E) margin = w1[1:0];
      if (code == 8'h08 || code == 8'h0B) margin = 0;
      stat({6'h20, f[0] | f[1] | f[2], f[1] | f[2]});
      check("margin_read", da_margin_read_o, margin != 0);
      chk_word(3'h1);
      chk_word(3'h3);
    end
  endtask : run_cmd

  task automatic report_and_stop();
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    stat(8'h80);
    check("pa_ok", pa_read_ok_o, 1'b1);
    for (int i = 0; i < 8; i++) put(3'(i), 16'($random(seed)));
    for (int i = 0; i < 8; i++) chk_word(3'(i));
    rd(3'h6);
    check("unmapped", rd_v, 8'h00);
    run_cmd(8'h02, 2'h0, 16'h0000, 3'h0, 8'h00);
    run_cmd(8'h02, 2'h1, 16'h0000, 3'h1, 8'h20);
    run_cmd(8'h08, 2'h0, 16'h0000, 3'h0, 8'h10);
    run_cmd(8'h09, 2'h0, 16'h4000, 3'h0, 8'h10);
    run_cmd(8'h0E, 2'h0, 16'h0001, 3'h0, 8'h20);
    run_cmd(8'h5A, 2'h0, 16'h0000, 3'h0, 8'h20);
    run_cmd(8'h11, 2'h0, 16'h0010, 3'h0, 8'h20);
    run_cmd(8'h09, 2'h2, 16'h0000, 3'h0, 8'h00);
    run_cmd(8'h0D, 2'h0, 16'h0002, 3'h1, 8'h00);
    run_cmd(8'h11, 2'h0, 16'h4010, 3'h3, 8'h00);
    run_cmd(8'h12, 2'h0, 16'h4200, 3'h0, 8'h00);
    run_cmd(8'h10, 2'h0, 16'h4100, 3'h0, 8'h00);
    run_cmd(8'h03, 2'h1, 16'h2000, 3'h0, 8'h00);
    run_cmd(8'h0D, 2'h0, 16'h0000, 3'h0, 8'h00);
    run_cmd(8'h10, 2'h0, 16'h4100, 3'h0, 8'h00);
    wr(3'h2, 8'h07);
    wr(3'h3, 8'h80);
    run_cmd(8'h09, 2'h0, 16'h4000, 3'h0, 8'h00);
    run_cmd(8'h08, 2'h0, 16'h0000, 3'h0, 8'h00);
    run_cmd(8'h0B, 2'h0, 16'h0000, 3'h0, 8'h00);
    @(posedge mclk_i);
    special_mode_i <= 1'b1;
    run_cmd(8'h0E, 2'h0, 16'h0001, 3'h0, 8'h00);
    report_and_stop();
  end
endmodule : nci_cmd_if_tb_top
